// File: rtl/fsrb_defines.vh
// Constants for the flash status register bank: bit positions, masks,
// reset values, command codes and the write cycle count.
// Assumes it is included by bare name from the design files.
`ifndef FSRB_DEFINES_VH
`define FSRB_DEFINES_VH

// Register one fields.
`define FSRB_SR1_PROT_LO     7
`define FSRB_SR1_SEC         6
`define FSRB_SR1_TB          5
`define FSRB_SR1_BP_HI       4
`define FSRB_SR1_BP_LO       2
`define FSRB_SR1_WEL         1
`define FSRB_SR1_BUSY        0

// Register two fields.
`define FSRB_SR2_ERASE_SUS   7
`define FSRB_SR2_CMP         6
`define FSRB_SR2_LB_HI       5
`define FSRB_SR2_LB_LO       3
`define FSRB_SR2_PROG_SUS    2
`define FSRB_SR2_QE          1
`define FSRB_SR2_PROT_HI     0

// Register three fields.
`define FSRB_SR3_HOLD_RESET_PIN_SEL        7
`define FSRB_SR3_DRV_HI      6
`define FSRB_SR3_DRV_LO      5
`define FSRB_SR3_HFM         4
`define FSRB_SR3_WPS         2
`define FSRB_SR3_DC          0

// Writable masks of the stored copies.
`define FSRB_SR1_MASK        8'hfc
`define FSRB_SR2_NV_MASK     8'h7b
`define FSRB_SR2_VOL_MASK    8'h43
`define FSRB_SR2_LB_MASK     8'h38
`define FSRB_SR3_MASK        8'hf5

// Reset values.
`define FSRB_SR1_RESET       8'h00
`define FSRB_SR2_RESET       8'h00
`define FSRB_SR3_RESET       8'h10

// Register selects.
`define FSRB_SEL_ONE         2'h1
`define FSRB_SEL_TWO         2'h2
`define FSRB_SEL_THREE       2'h3

// Command codes.
`define FSRB_CMD_WREN        8'h06
`define FSRB_CMD_WREN_VOL    8'h50
`define FSRB_CMD_WRDI        8'h04
`define FSRB_CMD_WRSR1       8'h01
`define FSRB_CMD_WRSR2       8'h31
`define FSRB_CMD_WRSR3       8'h11

// Protect mode encodings.
`define FSRB_PROT_SOFT       2'h0
`define FSRB_PROT_HW         2'h1
`define FSRB_PROT_PWR        2'h2

// Non-volatile write time and its cycle count.
`define FSRB_CLK_NS          40
`define FSRB_NV_WRITE_NS     640
`define FSRB_NV_WRITE_CYC    ((`FSRB_NV_WRITE_NS + `FSRB_CLK_NS - 1) / `FSRB_CLK_NS)
`define FSRB_CNT_W           8

`endif

// File: rtl/fsrb_pin_sync.v
// Three-stage synchroniser for pins entering the clk domain.
// Assumes the pins are asynchronous levels; the output moves only once
// the second and third stages agree.
module fsrb_pin_sync #(
    parameter W = 1
) (
    // Clock and reset
    input  wire         clk,
    input  wire         sys_rst,
    // Pins and clean levels
    input  wire [W-1:0] pin_in,
    output wire [W-1:0] level_out
);
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            reg s1;
            reg s2;
            reg s3;
            reg lvl;
            always @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    s1  <= 1'b1;
                    s2  <= 1'b1;
                    s3  <= 1'b1;
                    lvl <= 1'b1;
                end else begin
                    s1 <= pin_in[i];
                    s2 <= s1;
                    s3 <= s2;
                    // A lone disagreement is treated as a glitch and held off.
                    if (s2 == s3) begin
                        lvl <= s3;
                    end
                end
            end
            assign level_out[i] = lvl;
        end
    endgenerate
endmodule // fsrb_pin_sync

// File: rtl/fsrb_status_bank.v
// Status and configuration register bank of a serial NOR flash.
// Assumes an upstream command decoder that delivers decoded opcodes and
// write-status data bytes as one-cycle pulses, and engines that report done.
//
// How it works
// - Protect, lock, complement and quad fields have non-volatile storage.
// - Suspend, write-enable and busy bits are read-only, set internally.
// - Write-enable latch set by 06h only; cleared when an operation ends.
// - Non-volatile write needs 06h just before, protect bits and pin permitting.
// - Volatile working copies drive protection and quad behaviour.
// - Power-up and software reset reload working copies from non-volatile.
// - After 50h a status write changes only working copies, no write cycle.
// - Volatile writes need 50h just before, protect bits and pin permitting.
// - Sector select bit picks 4-KB sectors when 1, 64-KB blocks when 0.
// - Top/bottom bit grows protection from top when 0, bottom when 1.
// - Block-protect field of all zeros gives no protection while complement and bit 2 of register three are 0; reset default.
// - No program, erase or non-volatile register write starts while write-enable is 0.
// - Busy reads 1 during an embedded operation, else 0; resets to 0.
// - Erase and program suspend flags read 1 while suspended; reset 0.
// - Complement bit selects inverted protection map when 1.
// - Three one-time lock bits write-protect security registers three to one.
// - Quad enable turns protect and hold/reset pins into data lines.
// - Register three bit 7 selects hold or reset, only with quad off.
// - Register three bit 4 selects high frequency mode; default 1.
// - Register three bit 2 selects range protection or individual locks.
// - Register three bit 0 selects dummy cycles; volatile and stored copies.
// - Protect bits pick software, pin, power-cycle or permanent lock.
// - While busy, every instruction except status read and software reset is ignored; suspend is taken only during a program or erase.
// - Status write data never changes busy, write-enable or suspend bits.
`include "fsrb_defines.vh"

module fsrb_status_bank (
    // Clock and reset
    input  wire       clk,
    input  wire       sys_rst,
    // Reload events
    input  wire       power_up_pulse,
    input  wire       soft_reset_pulse,
    // Decoded commands
    input  wire       cmd_strobe,
    input  wire [7:0] cmd_code,
    // Write status data
    input  wire       wr_strobe,
    input  wire [1:0] wr_sel,
    input  wire [7:0] wr_data,
    // Status read
    input  wire [1:0] rd_sel,
    output reg  [7:0] rd_data,
    // Embedded operation engines
    input  wire       op_start_req,
    input  wire       op_is_erase,
    input  wire       op_done,
    input  wire       suspend_req,
    input  wire       resume_req,
    output reg        op_granted,
    output reg        op_refused,
    // Write-protect pin
    input  wire       wp_pin,
    // Status and configuration outputs
    output reg        busy,
    output reg        write_enable_latch,
    output reg        erase_suspended_flag,
    output reg        program_suspended_flag,
    output reg  [7:0] vol_one,
    output reg  [7:0] vol_two,
    output reg  [7:0] vol_three,
    output reg  [2:0] secreg_lock,
    output reg        wp_fn_en,
    output reg        hold_fn_en,
    output reg        reset_fn_en,
    output reg        range_prot_none
);
    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_NVWR = 4'b0010;
    localparam [3:0] ST_OP   = 4'b0100;
    localparam [3:0] ST_SUSP = 4'b1000;

    localparam integer           NV_CYC_FULL = `FSRB_NV_WRITE_CYC;
    localparam [`FSRB_CNT_W-1:0] NV_CYC      = NV_CYC_FULL[`FSRB_CNT_W-1:0];

    reg  [3:0]             state;
    reg  [`FSRB_CNT_W-1:0] cnt;
    reg  [7:0]             nv_one;
    reg  [7:0]             nv_two;
    reg  [7:0]             nv_three;
    reg                    arm_nv;
    reg                    arm_vol;
    reg                    op_erase;
    reg  [1:0]             pend_sel;
    reg  [7:0]             pend_data;
    wire                   wp_level;
    wire [1:0]             prot_mode;
    wire                   locked;
    wire                   reload;

    fsrb_pin_sync #(
        .W (1)
    ) u_wp_sync (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .pin_in    (wp_pin),
        .level_out (wp_level)
    );

    function [7:0] fsrb_merge;
        input [7:0] old_val;
        input [7:0] new_val;
        input [7:0] mask;
        begin
            fsrb_merge = (old_val & ~mask) | (new_val & mask);
        end
    endfunction

    // The stored protect bits gate status writes; the pin only counts with quad off.
    assign prot_mode = {nv_two[`FSRB_SR2_PROT_HI], nv_one[`FSRB_SR1_PROT_LO]};
    assign locked    = (prot_mode == `FSRB_PROT_HW) ? (~vol_two[`FSRB_SR2_QE] & ~wp_level)
                     : (prot_mode != `FSRB_PROT_SOFT);
    assign reload    = power_up_pulse | soft_reset_pulse;

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state                  <= ST_IDLE;
            cnt                    <= {`FSRB_CNT_W{1'b0}};
            nv_one                 <= `FSRB_SR1_RESET;
            nv_two                 <= `FSRB_SR2_RESET;
            nv_three               <= `FSRB_SR3_RESET;
            vol_one                <= `FSRB_SR1_RESET;
            vol_two                <= `FSRB_SR2_RESET;
            vol_three              <= `FSRB_SR3_RESET;
            arm_nv                 <= 1'b0;
            arm_vol                <= 1'b0;
            op_erase               <= 1'b0;
            pend_sel               <= 2'h0;
            pend_data              <= 8'h00;
            busy                   <= 1'b0;
            write_enable_latch     <= 1'b0;
            erase_suspended_flag   <= 1'b0;
            program_suspended_flag <= 1'b0;
            op_granted             <= 1'b0;
            op_refused             <= 1'b0;
        end else begin
            op_granted <= 1'b0;
            op_refused <= 1'b0;
            if (reload) begin
                // Power-cycle lock-down is released; a permanent lock stays.
                if (prot_mode == `FSRB_PROT_PWR) begin
                    nv_one[`FSRB_SR1_PROT_LO] <= 1'b0;
                    nv_two[`FSRB_SR2_PROT_HI] <= 1'b0;
                    vol_one <= nv_one & `FSRB_SR1_MASK & 8'h7f;
                    vol_two <= nv_two & `FSRB_SR2_VOL_MASK & 8'hfe;
                end else begin
                    vol_one <= nv_one & `FSRB_SR1_MASK;
                    vol_two <= nv_two & `FSRB_SR2_VOL_MASK;
                end
                vol_three              <= nv_three & `FSRB_SR3_MASK;
                state                  <= ST_IDLE;
                busy                   <= 1'b0;
                write_enable_latch     <= 1'b0;
                erase_suspended_flag   <= 1'b0;
                program_suspended_flag <= 1'b0;
                arm_nv                 <= 1'b0;
                arm_vol                <= 1'b0;
            end else begin
                case (state)
                    ST_IDLE, ST_SUSP: begin
                        if (cmd_strobe) begin
                            case (cmd_code)
                                `FSRB_CMD_WREN: begin
                                    write_enable_latch <= 1'b1;
                                    arm_nv             <= 1'b1;
                                    arm_vol            <= 1'b0;
                                end
                                `FSRB_CMD_WREN_VOL: begin
                                    arm_vol <= 1'b1;
                                    arm_nv  <= 1'b0;
                                end
                                `FSRB_CMD_WRDI: begin
                                    write_enable_latch <= 1'b0;
                                    arm_nv             <= 1'b0;
                                    arm_vol            <= 1'b0;
                                end
                                `FSRB_CMD_WRSR1, `FSRB_CMD_WRSR2, `FSRB_CMD_WRSR3: begin
                                    arm_nv  <= arm_nv;
                                    arm_vol <= arm_vol;
                                end
                                default: begin
                                    // Any other command breaks the required adjacency.
                                    arm_nv  <= 1'b0;
                                    arm_vol <= 1'b0;
                                end
                            endcase
                        end else if (wr_strobe) begin
                            arm_nv  <= 1'b0;
                            arm_vol <= 1'b0;
                            if (arm_vol && !locked) begin
                                case (wr_sel)
                                    `FSRB_SEL_ONE:
                                        vol_one <= fsrb_merge(vol_one, wr_data,
                                                              `FSRB_SR1_MASK);
                                    `FSRB_SEL_TWO:
                                        vol_two <= fsrb_merge(vol_two, wr_data,
                                                              `FSRB_SR2_VOL_MASK);
                                    `FSRB_SEL_THREE:
                                        vol_three <= fsrb_merge(vol_three, wr_data,
                                                                `FSRB_SR3_MASK);
                                    default:
                                        vol_one <= vol_one;
                                endcase
                            end else if (arm_nv && write_enable_latch && !locked) begin
                                state     <= ST_NVWR;
                                cnt       <= NV_CYC;
                                busy      <= 1'b1;
                                pend_sel  <= wr_sel;
                                pend_data <= wr_data;
                            end
                        end else if (resume_req && state == ST_SUSP) begin
                            state                  <= ST_OP;
                            busy                   <= 1'b1;
                            erase_suspended_flag   <= 1'b0;
                            program_suspended_flag <= 1'b0;
                        end else if (op_start_req) begin
                            if (write_enable_latch) begin
                                state      <= ST_OP;
                                busy       <= 1'b1;
                                op_erase   <= op_is_erase;
                                op_granted <= 1'b1;
                            end else begin
                                op_refused <= 1'b1;
                            end
                        end
                    end
                    ST_NVWR: begin
                        // Commands and data are dropped here; status reads and reload pulses still proceed.
                        cnt <= cnt - 1'b1;
                        if (cnt == 1) begin
                            state              <= ST_IDLE;
                            busy               <= 1'b0;
                            write_enable_latch <= 1'b0;
                            case (pend_sel)
                                `FSRB_SEL_ONE: begin
                                    nv_one  <= fsrb_merge(nv_one, pend_data,
                                                          `FSRB_SR1_MASK);
                                    vol_one <= fsrb_merge(vol_one, pend_data,
                                                          `FSRB_SR1_MASK);
                                end
                                `FSRB_SEL_TWO: begin
                                    // Lock bits can only be set, never cleared.
                                    nv_two  <= fsrb_merge(nv_two, pend_data,
                                                          `FSRB_SR2_VOL_MASK)
                                             | (pend_data & `FSRB_SR2_LB_MASK);
                                    vol_two <= fsrb_merge(vol_two, pend_data,
                                                          `FSRB_SR2_VOL_MASK);
                                end
                                `FSRB_SEL_THREE: begin
                                    nv_three  <= fsrb_merge(nv_three, pend_data,
                                                            `FSRB_SR3_MASK);
                                    vol_three <= fsrb_merge(vol_three, pend_data,
                                                            `FSRB_SR3_MASK);
                                end
                                default:
                                    nv_one <= nv_one;
                            endcase
                        end
                    end
                    ST_OP: begin
                        if (op_done) begin
                            state              <= ST_IDLE;
                            busy               <= 1'b0;
                            write_enable_latch <= 1'b0;
                        end else if (suspend_req) begin
                            state                  <= ST_SUSP;
                            busy                   <= 1'b0;
                            erase_suspended_flag   <= op_erase;
                            program_suspended_flag <= ~op_erase;
                        end
                    end
                    default: begin
                        state <= ST_IDLE;
                        busy  <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Readback and pin functions; reserved bits of register three read zero.
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_data         <= 8'h00;
            secreg_lock     <= 3'h0;
            wp_fn_en        <= 1'b1;
            hold_fn_en      <= 1'b1;
            reset_fn_en     <= 1'b0;
            range_prot_none <= 1'b1;
        end else begin
            case (rd_sel)
                `FSRB_SEL_ONE:
                    rd_data <= {vol_one[7:2], write_enable_latch, busy};
                `FSRB_SEL_TWO:
                    rd_data <= {erase_suspended_flag, vol_two[6], nv_two[5:3],
                                program_suspended_flag, vol_two[1:0]};
                `FSRB_SEL_THREE:
                    rd_data <= vol_three & `FSRB_SR3_MASK;
                default:
                    rd_data <= 8'h00;
            endcase
            secreg_lock     <= nv_two[`FSRB_SR2_LB_HI:`FSRB_SR2_LB_LO];
            wp_fn_en        <= ~vol_two[`FSRB_SR2_QE];
            hold_fn_en      <= ~vol_two[`FSRB_SR2_QE] & ~vol_three[`FSRB_SR3_HOLD_RESET_PIN_SEL];
            reset_fn_en     <= ~vol_two[`FSRB_SR2_QE] & vol_three[`FSRB_SR3_HOLD_RESET_PIN_SEL];
            range_prot_none <= ~vol_three[`FSRB_SR3_WPS] & ~vol_two[`FSRB_SR2_CMP]
                             & (vol_one[`FSRB_SR1_BP_HI:`FSRB_SR1_BP_LO] == 3'h0);
        end
    end
    // Sector, top/bottom, complement, frequency and dummy fields leave on
    // vol_one, vol_two and vol_three for the protection map and read logic.
endmodule // fsrb_status_bank

// File: bench/fsrb_status_bank_chk.sv
// Assertion checker for the flash status register bank top ports.
// Assumes one clock domain with an active-high asynchronous reset.
module fsrb_chk (
    // Clock, reset and requests
    input wire logic       clk, sys_rst, cmd_strobe, wr_strobe, op_start_req, suspend_req,
    input wire logic [7:0] cmd_code,
    // Engine handshake and status flags
    input wire logic       op_granted, op_refused, busy, write_enable_latch,
    input wire logic       erase_suspended_flag, program_suspended_flag,
    // Working copies and pin functions
    input wire logic [7:0] vol_one, vol_two, vol_three,
    input wire logic [2:0] secreg_lock,
    input wire logic       wp_fn_en, hold_fn_en, reset_fn_en, range_prot_none
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_wel_set;
        $rose(write_enable_latch) |-> $past(cmd_strobe) && $past(cmd_code) == 8'h06;
    endproperty
    a_wel_set: assert property (p_wel_set) else $error("latch set without enable");
    property p_wel_clr;
        $fell(busy) && !erase_suspended_flag && !program_suspended_flag |-> !write_enable_latch;
    endproperty
    a_wel_clr: assert property (p_wel_clr) else $error("latch kept after end");
    property p_refuse;
        op_refused |-> $past(op_start_req) && !$past(write_enable_latch) && !busy;
    endproperty
    a_refuse: assert property (p_refuse) else $error("bad refusal");
    property p_grant;
        op_granted |-> $past(op_start_req) && $past(write_enable_latch) && busy;
    endproperty
    a_grant: assert property (p_grant) else $error("bad grant");
    property p_susp;
        $rose(erase_suspended_flag) || $rose(program_suspended_flag) |-> $past(suspend_req);
    endproperty
    a_susp: assert property (p_susp) else $error("suspend flag without request");
    // Status writes are refused while busy, so secreg_lock and vol_one may not move until busy drops.
    property p_busy_hold;
        busy |=> !busy || ($stable(secreg_lock) && $stable(vol_one));
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("state moved while busy");
    property p_vol_fast;
        cmd_strobe && cmd_code == 8'h50 && !busy ##1 wr_strobe |=> !busy [*2];
    endproperty
    a_vol_fast: assert property (p_vol_fast) else $error("volatile write went busy");
    property p_pin_fn;
        {wp_fn_en, hold_fn_en, reset_fn_en} ==
            ($past(vol_two[1]) ? 3'b000 : (3'b110 ^ {1'b0, {2{$past(vol_three[7])}}}));
    endproperty
    a_pin_fn: assert property (p_pin_fn) else $error("pin functions wrong");
    property p_range;
        range_prot_none == (($past(vol_one) & 8'h1c) == 8'h00 && !$past(vol_two[6])
            && !$past(vol_three[2]));
    endproperty
    a_range: assert property (p_range) else $error("range flag wrong");
    c_grant: cover property (op_granted);
    c_refuse: cover property (op_refused);
    c_prog_sus: cover property ($rose(program_suspended_flag));
endmodule // fsrb_chk

// File: bench/fsrb_host_model.sv
// Host model issuing decoded commands, status bytes and read selects.
// Assumes each task is entered at a falling clock edge and returns at one.
module fsrb_host_model (
    // Clock
    input wire logic  clk,
    // Commands and status bytes
    output logic       cmd_strobe,
    output logic [7:0] cmd_code,
    output logic       wr_strobe,
    output logic [1:0] wr_sel,
    output logic [7:0] wr_data,
    // Status read select
    output logic [1:0] rd_sel
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {cmd_strobe, wr_strobe, cmd_code, wr_sel, wr_data, rd_sel} = 22'h0;
    end
    task automatic issue(input logic [7:0] code);
        cmd_strobe = 1'b1;
        cmd_code = code;
        @(negedge clk);
        cmd_strobe = 1'b0;
        // A released line must not look like a held one.
        cmd_code = ~code;
    endtask
    task automatic put(input logic [1:0] sel, input logic [7:0] b);
        wr_strobe = 1'b1;
        {wr_sel, wr_data} = {sel, b};
        @(negedge clk);
        wr_strobe = 1'b0;
        {wr_sel, wr_data} = ~{sel, b};
    endtask
    task automatic status_write(input logic [7:0] en, input logic [1:0] sel, input logic [7:0] b);
        issue(en);
        put(sel, b);
    endtask
    task automatic read(input logic [1:0] sel);
        rd_sel = sel;
    endtask
endmodule // fsrb_host_model

// File: bench/fsrb_status_bank_test.sv
// Self-checking bench for the flash status register bank.
// Assumes the host model drives commands; engines and pins are driven here.
module fsrb_status_bank_test;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct { string nm; logic [7:0] v; logic [7:0] m; } fsrb_note_t;
    fsrb_note_t q[$];
    fsrb_note_t cur;
    event       seen_ev;
    int         n_fail = 0, checked = 0, cycles = 0, seed = 49861, k;
    logic [7:0] d;
    logic       clk = 1'b0, sys_rst = 1'b1, wp_pin = 1'b1, op_is_erase = 1'b0;
    logic       power_up_pulse = 1'b0, soft_reset_pulse = 1'b0, op_start_req = 1'b0;
    logic       op_done = 1'b0, suspend_req = 1'b0, resume_req = 1'b0;
    wire        cmd_strobe, wr_strobe, op_granted, op_refused, busy, write_enable_latch;
    wire        erase_suspended_flag, program_suspended_flag, wp_fn_en, hold_fn_en;
    wire        reset_fn_en, range_prot_none;
    wire [7:0]  cmd_code, wr_data, rd_data, vol_one, vol_two, vol_three;
    wire [1:0]  wr_sel, rd_sel;
    wire [2:0]  secreg_lock;
    always #20 clk = ~clk;
    fsrb_host_model host (.clk, .cmd_strobe, .cmd_code, .wr_strobe, .wr_sel, .wr_data, .rd_sel);
    fsrb_status_bank DUT (
        .clk, .sys_rst, .power_up_pulse, .soft_reset_pulse, .cmd_strobe, .cmd_code,
        .wr_strobe, .wr_sel, .wr_data, .rd_sel, .rd_data, .op_start_req, .op_is_erase,
        .op_done, .suspend_req, .resume_req, .op_granted, .op_refused, .wp_pin, .busy,
        .write_enable_latch, .erase_suspended_flag, .program_suspended_flag, .vol_one,
        .vol_two, .vol_three, .secreg_lock, .wp_fn_en, .hold_fn_en, .reset_fn_en,
        .range_prot_none
    );
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Two edges pass so that registered updates settle before the read is taken.
    task automatic look(input string nm, input logic [1:0] sel, input logic [7:0] v, m);
        host.read(sel);
        repeat (2) @(negedge clk);
        q.push_back('{nm, v, m});
        -> seen_ev;
    endtask
    task automatic pulse(input int n);
        {power_up_pulse, soft_reset_pulse, op_start_req, op_done, suspend_req, resume_req}
            = 6'h20 >> n;
        @(negedge clk);
        {power_up_pulse, soft_reset_pulse, op_start_req, op_done, suspend_req, resume_req}
            = 6'h00;
    endtask
    task automatic wait_idle;
        int i;
        @(negedge clk);
        for (i = 0; i < 40 && busy !== 1'b0; i++) @(negedge clk);
        check("busy_end", {7'h00, busy}, 8'h00);
    endtask
    task automatic tally_and_finish;
        if (n_fail == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(seen_ev) begin
        cur = q.pop_front();
        check(cur.nm, rd_data & cur.m, cur.v & cur.m);
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            tally_and_finish;
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        @(negedge clk) sys_rst = 1'b0;
        look("status_one", 2'h1, 8'h00, 8'hff);
        look("status_two", 2'h2, 8'h00, 8'hff);
        look("status_three", 2'h3, 8'h10, 8'hf5);
        d = 8'($random(seed)) & 8'h7c;
        host.status_write(8'h50, 2'h1, d | 8'h03);
        look("volatile_one", 2'h1, d, 8'hff);
        pulse(1);
        look("reload_one", 2'h1, 8'h00, 8'hff);
        host.issue(8'h50);
        @(negedge clk);
        host.issue(8'h04);
        host.put(2'h1, 8'h1c);
        look("disarmed_one", 2'h1, 8'h00, 8'hff);
        d = 8'($random(seed)) & 8'hf5;
        host.status_write(8'h06, 2'h3, d);
        look("busy_one", 2'h1, 8'h03, 8'h03);
        host.status_write(8'h50, 2'h1, 8'h1c);
        wait_idle;
        look("after_busy_one", 2'h1, 8'h00, 8'hff);
        pulse(0);
        look("stored_three", 2'h3, d, 8'hf5);
        host.status_write(8'h06, 2'h1, 8'h80);
        wait_idle;
        wp_pin = 1'b0;
        repeat (5) @(negedge clk);
        host.status_write(8'h50, 2'h1, 8'h9c);
        look("pin_locked_one", 2'h1, 8'h80, 8'hff);
        wp_pin = 1'b1;
        repeat (5) @(negedge clk);
        host.status_write(8'h50, 2'h1, 8'h8c);
        look("pin_free_one", 2'h1, 8'h8c, 8'hff);
        host.status_write(8'h06, 2'h1, 8'h00);
        wait_idle;
        host.status_write(8'h06, 2'h2, 8'h09);
        wait_idle;
        look("lock_two", 2'h2, 8'h09, 8'hff);
        check("secreg_lock", {5'h00, secreg_lock}, 8'h01);
        host.status_write(8'h50, 2'h1, 8'h1c);
        look("power_locked_one", 2'h1, 8'h00, 8'hff);
        pulse(1);
        look("unlocked_two", 2'h2, 8'h08, 8'hff);
        host.status_write(8'h06, 2'h2, 8'h42);
        wait_idle;
        look("otp_kept_two", 2'h2, 8'h4a, 8'hff);
        for (k = 0; k < 2; k++) begin
            pulse(2);
            host.issue(8'h06);
            op_is_erase = k[0];
            pulse(2);
            @(negedge clk);
            pulse(4);
            look("suspended_two", 2'h2, k ? 8'h80 : 8'h04, 8'h84);
            pulse(5);
            look("resumed_one", 2'h1, 8'h03, 8'h03);
            pulse(3);
            look("done_one", 2'h1, 8'h00, 8'h03);
        end
        @(negedge clk);
        tally_and_finish;
    end
endmodule // fsrb_status_bank_test
bind fsrb_status_bank fsrb_chk chk (
    .clk, .sys_rst, .cmd_strobe, .wr_strobe, .op_start_req, .suspend_req, .cmd_code,
    .op_granted, .op_refused, .busy, .write_enable_latch, .erase_suspended_flag,
    .program_suspended_flag, .vol_one, .vol_two, .vol_three, .secreg_lock, .wp_fn_en,
    .hold_fn_en, .reset_fn_en, .range_prot_none
);
